// *** hdl/sar_top.sv ***
// Serial port receive side with wake-up, break transmit and sync master pin mode.
// Assumes AXI4-Lite master on aclk and an asynchronous remote node on the pins.
module sar_top
  import sar_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  output logic sync_data_line_o,
  output logic sync_data_line_oe,
  output logic receive_irq,
  output logic receive_irq_high,
  output logic transmit_irq
);
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr
    $error("sar_top: ADDR_W must be 6 to 8");
  end

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= SAR_OFF_TX_BUFFER);
  endfunction : is_mapped

  // Register state
  logic [7:0] rs_q, ts_q, bc_q, divh_q, divl_q, ie_q, ip_q;
  logic framing_error_flag_q, overrun_error_flag_q, ninth_q, rx_full_q, wake_flag_q, wake_seen_q;
  logic [7:0] rx_data_q, tx_buf_q;
  logic tx_buf_full_q;

  // AXI write and read channel state
  logic aw_held_q, w_held_q, bvalid_q, wstrb0_q, rvalid_q;
  logic [7:0] awaddr_q, wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_write, wr_en, ar_take, rd_pop;
  logic [7:0] araddr8, rd_mux;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {24'h000000, rdata_q};
  assign do_write = aw_held_q && w_held_q;
  assign wr_en = do_write && wstrb0_q && is_mapped(awaddr_q);
  assign ar_take = s_axi_arvalid && !rvalid_q;
  assign araddr8 = 8'(s_axi_araddr);
  assign rd_pop = ar_take && (araddr8 == SAR_OFF_RX_BUFFER);

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= SAR_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q) ? SAR_RESP_OKAY : SAR_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Baud generator and x16 oversample tick
  logic [15:0] brg_cnt_q, brg_div;
  logic [1:0] pre_cnt_q;
  logic brg_tick, os_tick, x16_mode;
  assign brg_div = bc_q[SAR_BC_DIV16] ? {divh_q, divl_q} : {8'h00, divl_q};
  assign brg_tick = (brg_cnt_q == 16'h0000);
  assign x16_mode = ts_q[SAR_TS_HIGH_BAUD] || bc_q[SAR_BC_DIV16];
  assign os_tick = brg_tick && (x16_mode || pre_cnt_q == SAR_X64_PRE_LAST); // [RULE_01]

  always_ff @(posedge aclk) begin
    if (!aresetn || !rs_q[SAR_RS_PORT_EN]) begin
      brg_cnt_q <= 16'h0000;
      pre_cnt_q <= 2'h0;
    end else begin
      brg_cnt_q <= brg_tick ? brg_div : brg_cnt_q - 16'h0001;
      if (brg_tick) begin
        pre_cnt_q <= pre_cnt_q + 2'h1;
      end
    end
  end

  // Receive line synchroniser and edges
  logic rx_meta_q, rx_sync_q, rx_prev_q, rx_fall, rx_rise;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= serial_receive_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end
  assign rx_fall = rx_prev_q && !rx_sync_q;
  assign rx_rise = !rx_prev_q && rx_sync_q;

  // Mode decode
  logic async_mode, sync_master, rx_run, tx_idle, rx_idle;
  sar_rx_state_t rx_state_q;
  sar_tx_state_t tx_state_q;
  assign async_mode = rs_q[SAR_RS_PORT_EN] && !ts_q[SAR_TS_SYNC_SEL]; // [RULE_02]
  assign sync_master = rs_q[SAR_RS_PORT_EN] && ts_q[SAR_TS_SYNC_SEL]
                       && ts_q[SAR_TS_CLK_SRC]; // [RULE_20]
  assign tx_idle = (tx_state_q == SAR_TX_IDLE);
  assign rx_idle = (rx_state_q == SAR_RX_IDLE);
  assign rx_run = rs_q[SAR_RS_PORT_EN] && rs_q[SAR_RS_CONT_RX] && !bc_q[SAR_BC_WAKE_EN]
                  && !overrun_error_flag_q && (async_mode || tx_idle); // [RULE_02] [RULE_07] [RULE_21]

  // Receive engine
  logic [3:0] rx_os_q, rx_bit_q;
  logic [8:0] rx_sh_q;
  logic char_done, stop_ok, accept, rx_load, rx_overrun, buf_busy;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_q <= SAR_RX_IDLE;
      rx_os_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
    end else if (!rx_run) begin
      rx_state_q <= SAR_RX_IDLE;
    end else begin
      case (rx_state_q)
        SAR_RX_IDLE: begin
          if (rx_fall && (async_mode || !sync_master)) begin
            rx_state_q <= SAR_RX_START;
            rx_os_q <= 4'h0;
          end
        end
        SAR_RX_START: begin
          if (os_tick) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == SAR_OS_MID) begin
              rx_state_q <= rx_sync_q ? SAR_RX_IDLE : SAR_RX_DATA;
              rx_os_q <= 4'h0;
              rx_bit_q <= 4'h0;
            end
          end
        end
        SAR_RX_DATA: begin
          if (os_tick) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == SAR_OS_LAST) begin
              rx_sh_q <= {rx_sync_q, rx_sh_q[8:1]}; // [RULE_01] [RULE_23]
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == (rs_q[SAR_RS_NINE_EN] ? 4'h8 : 4'h7)) begin
                rx_state_q <= SAR_RX_STOP;
              end
            end
          end
        end
        SAR_RX_STOP: begin
          if (os_tick) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == SAR_OS_LAST) begin
              rx_state_q <= SAR_RX_IDLE;
            end
          end
        end
        default: rx_state_q <= SAR_RX_IDLE;
      endcase
    end
  end

  assign char_done = rx_run && (rx_state_q == SAR_RX_STOP) && os_tick && (rx_os_q == SAR_OS_LAST);
  assign stop_ok = rx_sync_q;
  assign accept = !(rs_q[SAR_RS_NINE_EN] && rs_q[SAR_RS_ADDR_DET]) || rx_sh_q[8]; // [RULE_06] [RULE_24]
  assign buf_busy = rx_full_q && !rd_pop;
  assign rx_load = char_done && accept && !buf_busy;
  assign rx_overrun = char_done && accept && buf_busy;

  // Receive buffer, ninth bit and errors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_q <= 1'b0;
      rx_data_q <= 8'h00;
      ninth_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_full_q <= 1'b1; // [RULE_03]
        rx_data_q <= rs_q[SAR_RS_NINE_EN] ? rx_sh_q[7:0] : rx_sh_q[8:1];
        ninth_q <= rs_q[SAR_RS_NINE_EN] && rx_sh_q[8]; // [RULE_04]
      end else if (rd_pop) begin
        rx_full_q <= 1'b0;
      end
      if (!rs_q[SAR_RS_CONT_RX]) begin
        framing_error_flag_q <= 1'b0; // [RULE_05]
        overrun_error_flag_q <= 1'b0;
      end else begin
        if (rx_load) begin
          framing_error_flag_q <= !stop_ok; // [RULE_25]
        end
        if (rx_overrun) begin
          overrun_error_flag_q <= 1'b1; // [RULE_25]
        end
      end
    end
  end

  // Wake-up on falling line, auto clear on next rising line
  logic wake_set, wake_end;
  assign wake_set = bc_q[SAR_BC_WAKE_EN] && rs_q[SAR_RS_PORT_EN] && rx_fall && !wake_seen_q;
  assign wake_end = wake_seen_q && rx_rise;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_seen_q <= 1'b0;
      wake_flag_q <= 1'b0;
    end else begin
      if (wake_set) begin
        wake_seen_q <= 1'b1; // [RULE_07]
      end else if (wake_end || !bc_q[SAR_BC_WAKE_EN]) begin
        wake_seen_q <= 1'b0;
      end
      // Clocked core: request is raised synchronously
      if (wake_set) begin
        wake_flag_q <= 1'b1; // [RULE_08] [RULE_09] [RULE_19]
      end else if (rd_pop) begin
        wake_flag_q <= 1'b0; // [RULE_10]
      end
    end
  end

  // Transmit buffer and shifter
  logic tx_load, tx_brk_q, tx_line_q, tx_wr;
  logic [3:0] tx_os_q, tx_bit_q, tx_last;
  logic [8:0] tx_sh_q;
  assign tx_wr = wr_en && (awaddr_q == SAR_OFF_TX_BUFFER);
  assign tx_load = tx_idle && tx_buf_full_q && ts_q[SAR_TS_TX_EN] && rs_q[SAR_RS_PORT_EN]
                   && (async_mode || rx_idle); // [RULE_21]
  assign tx_last = tx_brk_q ? SAR_BRK_BITS - 4'h1 : (ts_q[SAR_TS_NINE_TX] ? 4'h8 : 4'h7);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_q <= 8'h00;
      tx_buf_full_q <= 1'b0;
    end else if (tx_wr) begin
      tx_buf_q <= wdata_q;
      tx_buf_full_q <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_q <= SAR_TX_IDLE;
      tx_os_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h000;
      tx_brk_q <= 1'b0;
      tx_line_q <= 1'b1;
    end else begin
      case (tx_state_q)
        SAR_TX_IDLE: begin
          tx_line_q <= 1'b1;
          if (tx_load) begin
            tx_state_q <= SAR_TX_START;
            tx_line_q <= 1'b0;
            tx_os_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_brk_q <= ts_q[SAR_TS_SEND_BRK]; // [RULE_15]
            tx_sh_q <= ts_q[SAR_TS_SEND_BRK] ? 9'h000 : {ts_q[SAR_TS_NINTH_TX], tx_buf_q};
          end
        end
        SAR_TX_START: begin
          if (os_tick) begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == SAR_OS_LAST) begin
              tx_state_q <= SAR_TX_DATA;
              tx_line_q <= tx_sh_q[0]; // [RULE_23]
            end
          end
        end
        SAR_TX_DATA: begin
          if (os_tick) begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == SAR_OS_LAST) begin
              tx_bit_q <= tx_bit_q + 4'h1;
              tx_sh_q <= {1'b0, tx_sh_q[8:1]};
              if (tx_bit_q == tx_last) begin
                tx_state_q <= SAR_TX_STOP; // [RULE_14]
                tx_line_q <= 1'b1;
              end else begin
                tx_line_q <= tx_sh_q[1];
              end
            end
          end
        end
        SAR_TX_STOP: begin
          if (os_tick) begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == SAR_OS_LAST) begin
              tx_state_q <= SAR_TX_IDLE;
              tx_brk_q <= 1'b0;
            end
          end
        end
        default: tx_state_q <= SAR_TX_IDLE;
      endcase
    end
  end

  logic brk_done;
  assign brk_done = tx_brk_q && (tx_state_q == SAR_TX_STOP) && os_tick && (tx_os_q == SAR_OS_LAST);

  // Control registers; software writes win over hardware clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs_q <= SAR_REG_RST;
      ts_q <= SAR_REG_RST;
      bc_q <= SAR_REG_RST;
      divh_q <= SAR_REG_RST;
      divl_q <= SAR_REG_RST;
      ie_q <= SAR_REG_RST;
      ip_q <= SAR_REG_RST;
    end else begin
      if (brk_done) begin
        ts_q[SAR_TS_SEND_BRK] <= 1'b0; // [RULE_16]
      end
      if (wake_end) begin
        bc_q[SAR_BC_WAKE_EN] <= 1'b0; // [RULE_11]
      end
      if (wr_en) begin
        case (awaddr_q)
          SAR_OFF_RX_STATUS: rs_q <= wdata_q & SAR_RS_WMASK;
          SAR_OFF_TX_STATUS: ts_q <= wdata_q & SAR_TS_WMASK;
          SAR_OFF_BAUD_CTRL: bc_q <= wdata_q & SAR_BC_WMASK;
          SAR_OFF_DIV_HIGH: divh_q <= wdata_q;
          SAR_OFF_DIV_LOW: divl_q <= wdata_q;
          SAR_OFF_ENABLES: ie_q <= wdata_q & SAR_FL_WMASK;
          SAR_OFF_PRIORITY: ip_q <= wdata_q & SAR_FL_WMASK;
          default: ;
        endcase
      end
    end
  end

  // Read mux and read channel
  logic rx_flag, tx_flag;
  assign rx_flag = rx_full_q || wake_flag_q;
  assign tx_flag = !tx_buf_full_q && ts_q[SAR_TS_TX_EN];
  always_comb begin
    case (araddr8)
      SAR_OFF_RX_STATUS: rd_mux = rs_q | {5'b00000, framing_error_flag_q, overrun_error_flag_q, ninth_q}; // [RULE_04] [RULE_05]
      SAR_OFF_RX_BUFFER: rd_mux = rx_data_q; // [RULE_03]
      SAR_OFF_TX_STATUS: rd_mux = ts_q | {6'b000000, tx_idle, 1'b0};
      SAR_OFF_BAUD_CTRL: rd_mux = bc_q | {1'b0, !rx_idle, 6'b000000}; // [RULE_12]
      SAR_OFF_DIV_HIGH: rd_mux = divh_q;
      SAR_OFF_DIV_LOW: rd_mux = divl_q;
      SAR_OFF_FLAGS: rd_mux = {2'b00, rx_flag, tx_flag, 4'h0};
      SAR_OFF_ENABLES: rd_mux = ie_q;
      SAR_OFF_PRIORITY: rd_mux = ip_q;
      SAR_OFF_TX_BUFFER: rd_mux = tx_buf_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= SAR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= is_mapped(araddr8) ? SAR_RESP_OKAY : SAR_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Pins and requests
  logic pin_q, dt_q, dt_oe_q, irq_q, irqh_q, tirq_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b1;
      dt_q <= 1'b1;
      dt_oe_q <= 1'b0;
      irq_q <= 1'b0;
      irqh_q <= 1'b0;
      tirq_q <= 1'b0;
    end else begin
      pin_q <= sync_master ? bc_q[SAR_BC_CLK_POL] : tx_line_q; // [RULE_20] [RULE_22]
      dt_q <= tx_line_q;
      dt_oe_q <= sync_master && !tx_idle;
      irq_q <= rx_flag && ie_q[SAR_FL_RX]; // [RULE_03]
      irqh_q <= rx_flag && ie_q[SAR_FL_RX] && ip_q[SAR_FL_RX];
      tirq_q <= tx_flag && ie_q[SAR_FL_TX];
    end
  end
  assign serial_transmit_pin = pin_q;
  assign sync_data_line_o = dt_q;
  assign sync_data_line_oe = dt_oe_q;
  assign receive_irq = irq_q;
  assign receive_irq_high = irqh_q;
  assign transmit_irq = tirq_q;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wake_fall;
    wake_set && !rd_pop;
  endsequence
  sequence s_wake_flag_seen;
    rx_flag ##1 (receive_irq || !ie_q[SAR_FL_RX]);
  endsequence

  a_load_raises_flag: assert property ( // [RULE_03]
    rx_load |=> rx_flag && rx_full_q) else $error("load did not raise flag");
  a_irq_needs_enable: assert property ( // [RULE_03]
    $rose(receive_irq) |-> $past(ie_q[SAR_FL_RX]) && $past(rx_flag))
    else $error("irq without enable");
  a_err_clear_continuous_receive_enable: assert property ( // [RULE_05]
    !rs_q[SAR_RS_CONT_RX] |=> !framing_error_flag_q && !overrun_error_flag_q) else $error("errors not cleared");
  a_wake_blocks_rx: assert property ( // [RULE_07]
    bc_q[SAR_BC_WAKE_EN] && $past(bc_q[SAR_BC_WAKE_EN]) |-> rx_idle)
    else $error("reception while wake enabled");
  a_wake_sets_flag: assert property ( // [RULE_08]
    s_wake_fall |=> s_wake_flag_seen) else $error("wake edge lost");
  a_pop_clears_wake: assert property ( // [RULE_10]
    rd_pop && !rx_load && !wake_set |=> !rx_flag) else $error("read left flag set");
  a_wake_auto_clear: assert property ( // [RULE_11]
    wake_end && !(wr_en && awaddr_q == SAR_OFF_BAUD_CTRL) |=> !bc_q[SAR_BC_WAKE_EN])
    else $error("wake enable not cleared");
  a_addr_filter: assert property ( // [RULE_24]
    char_done && rs_q[SAR_RS_NINE_EN] && rs_q[SAR_RS_ADDR_DET] && !rx_sh_q[8]
    |=> $stable(rx_data_q) && !overrun_error_flag_q || !rs_q[SAR_RS_CONT_RX] || $past(overrun_error_flag_q))
    else $error("non-address character stored");
  a_break_low: assert property ( // [RULE_15]
    tx_brk_q && tx_state_q == SAR_TX_DATA |-> tx_line_q == 1'b0) else $error("break not low");
  a_break_ends: assert property ( // [RULE_16]
    brk_done && !(wr_en && awaddr_q == SAR_OFF_TX_STATUS) |=> !ts_q[SAR_TS_SEND_BRK] && tx_idle)
    else $error("send-break not cleared");
  a_frame_error: assert property ( // [RULE_25]
    rx_load && !stop_ok && rs_q[SAR_RS_CONT_RX] |=> framing_error_flag_q) else $error("framing error missed");
endmodule : sar_top

// *** hdl/sar_pkg.sv ***
// Constants, register map and state types of the asynchronous serial receiver block.
// Assumes one 250 MHz clock, synchronous active-low reset, AXI4-Lite register access.
//
// Contract
// RULE_01 - Receive line is oversampled sixteen times per bit; main shifter moves per bit.
// RULE_02 - Async mode needs port enable set, synchronous select clear; continuous enable receives.
// RULE_03 - Finished character sets receive-complete flag; interrupt only if enabled; data readable.
// RULE_04 - Ninth bit captured in nine-bit mode, readable in receive status register.
// RULE_05 - Errors shown in receive status; clearing continuous enable clears latched errors.
// RULE_06 - Nine-bit plus address detect withholds non-address characters from buffer and flag.
// RULE_07 - Wake-up enable suspends reception; block idles watching the receive line.
// RULE_08 - Falling receive line during wake-up sets the receive-complete flag.
// RULE_09 - Wake-up request synchronous when clocked; asynchronous only when clocks stopped.
// RULE_10 - Reading receive buffer clears wake-up condition; data returned is dummy.
// RULE_11 - Next rising receive line after wake-up clears wake-up enable automatically.
// RULE_12 - Read-only receive-in-progress bit shows an active reception.
// RULE_13 - Remote sender starts auto-wake-up traffic with an all-zero character.
// RULE_14 - Break is one start bit, twelve low bits, one stop bit.
// RULE_15 - Send-break with transmit enable sends break on shift load, ignoring data.
// RULE_16 - Send-break clears after break stop bit; preloaded byte then goes normally.
// RULE_17 - Host sets enable and send-break, writes dummy, then writes sync byte.
// RULE_18 - Software may receive break by setting baud to nine-thirteenths nominal.
// RULE_19 - Break via auto-wake-up: flag on transitions, then next byte flags again.
// RULE_20 - Clock source, synchronous select and port enable together enter sync master.
// RULE_21 - Sync master is half duplex: transmit and receive exclude each other.
// RULE_22 - Sync master drives clock line; polarity bit sets idle level high.
// RULE_23 - Frame is start bit, eight or nine data bits LSB first, stop bit.
// RULE_24 - Address detect loads only characters whose ninth bit is one.
// RULE_25 - Low stop bit sets framing error; full buffer completion sets overrun, halts.
package sar_pkg;
  // Register byte offsets
  localparam logic [7:0] SAR_OFF_RX_STATUS = 8'h00;
  localparam logic [7:0] SAR_OFF_RX_BUFFER = 8'h04;
  localparam logic [7:0] SAR_OFF_TX_STATUS = 8'h08;
  localparam logic [7:0] SAR_OFF_BAUD_CTRL = 8'h0c;
  localparam logic [7:0] SAR_OFF_DIV_HIGH = 8'h10;
  localparam logic [7:0] SAR_OFF_DIV_LOW = 8'h14;
  localparam logic [7:0] SAR_OFF_FLAGS = 8'h18;
  localparam logic [7:0] SAR_OFF_ENABLES = 8'h1c;
  localparam logic [7:0] SAR_OFF_PRIORITY = 8'h20;
  localparam logic [7:0] SAR_OFF_TX_BUFFER = 8'h24;
  // Receive status/control bits
  localparam int SAR_RS_PORT_EN = 7;
  localparam int SAR_RS_NINE_EN = 6;
  localparam int SAR_RS_CONT_RX = 4;
  localparam int SAR_RS_ADDR_DET = 3;
  // Transmit status/control bits
  localparam int SAR_TS_CLK_SRC = 7;
  localparam int SAR_TS_NINE_TX = 6;
  localparam int SAR_TS_TX_EN = 5;
  localparam int SAR_TS_SYNC_SEL = 4;
  localparam int SAR_TS_SEND_BRK = 3;
  localparam int SAR_TS_HIGH_BAUD = 2;
  localparam int SAR_TS_NINTH_TX = 0;
  // Baud control bits
  localparam int SAR_BC_CLK_POL = 4;
  localparam int SAR_BC_DIV16 = 3;
  localparam int SAR_BC_WAKE_EN = 1;
  // Flag, enable and priority bits
  localparam int SAR_FL_RX = 5;
  localparam int SAR_FL_TX = 4;
  // Writable masks and reset values
  localparam logic [7:0] SAR_RS_WMASK = 8'hf8;
  localparam logic [7:0] SAR_TS_WMASK = 8'hfd;
  localparam logic [7:0] SAR_BC_WMASK = 8'h3b;
  localparam logic [7:0] SAR_FL_WMASK = 8'h30;
  localparam logic [7:0] SAR_REG_RST = 8'h00;
  // Timing counts and bus response codes
  localparam logic [3:0] SAR_OS_LAST = 4'hf;
  localparam logic [3:0] SAR_OS_MID = 4'h7;
  localparam logic [1:0] SAR_X64_PRE_LAST = 2'h3;
  localparam logic [3:0] SAR_BRK_BITS = 4'hc;
  localparam logic [1:0] SAR_RESP_OKAY = 2'h0;
  localparam logic [1:0] SAR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SAR_RX_IDLE, SAR_RX_START, SAR_RX_DATA, SAR_RX_STOP} sar_rx_state_t;
  typedef enum logic [1:0] {SAR_TX_IDLE, SAR_TX_START, SAR_TX_DATA, SAR_TX_STOP} sar_tx_state_t;
endpackage : sar_pkg

// *** bench/sar_node.sv ***
// Remote serial node model driving the receive line of the block.
// Bit length is bit_clks clocks, sixteen unless a scenario slows the line.
module sar_node (
  input wire logic aclk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_clks = 16;
  initial line = 1'h1;
  // Start, data LSB first, stop, then one idle clock; bits past nine are low
  task automatic send(input logic [8:0] data, input int nbits, input logic stop);
    for (int i = -1; i <= nbits; i++) begin
      line <= (i < 0) ? 1'h0 : (i == nbits) ? stop : (i < 9) ? data[i] : 1'h0;
      repeat (bit_clks) @(posedge aclk);
    end
    line <= 1'h1;
    @(posedge aclk);
  endtask : send
endmodule : sar_node

// *** bench/tb_serial_async_rx_break_wake.sv ***
// Self-checking bench: register bus master, serial node, transmit line watch.
// Assumes one tick per clock, so one bit lasts sixteen clocks, except in t_brk_rx where a tick every two clocks makes a bit 32 clocks.
module tb_serial_async_rx_break_wake
  import sar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic rx_line, tx_pin, irq, irqh;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int errors, check_count;
  sar_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
    .serial_receive_pin(rx_line), .serial_transmit_pin(tx_pin), .sync_data_line_o(),
    .sync_data_line_oe(), .receive_irq(irq), .receive_irq_high(irqh), .transmit_irq()
  );
  sar_node node (.aclk(aclk), .line(rx_line));
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  task automatic give_verdict();
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a[5:0];
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a[5:0];
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata[7:0];
    r = rresp;
  endtask : axr
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d & m, e);
  endtask : rchk
  task automatic low_run(output int n);
    n = 0;
    for (int i = 0; i < 2000 && tx_pin; i++) @(posedge aclk);
    while (!tx_pin && n < 400) begin
      @(posedge aclk);
      n++;
    end
  endtask : low_run
  task automatic t_regs();
    logic [7:0] d;
    logic [1:0] r;
    rchk(SAR_OFF_RX_STATUS, 8'hff, SAR_REG_RST);
    axr(8'h28, d, r);
    chk({6'h0, r}, {6'h0, SAR_RESP_SLVERR});
  endtask : t_regs
  task automatic t_rx();
    axw(SAR_OFF_TX_STATUS, 8'h04);
    axw(SAR_OFF_ENABLES, 8'h20);
    axw(SAR_OFF_PRIORITY, 8'h20);
    axw(SAR_OFF_RX_STATUS, 8'h80);
    node.send(9'h04b, 8, 1'h1);
    rchk(SAR_OFF_FLAGS, 8'h20, 8'h00);
    axw(SAR_OFF_RX_STATUS, 8'h90);
    fork
      node.send(9'h04b, 8, 1'h1);
      begin
        repeat (80) @(posedge aclk);
        rchk(SAR_OFF_BAUD_CTRL, 8'h40, 8'h40);
      end
    join
    chk({6'h0, irqh, irq}, 8'h03);
    rchk(SAR_OFF_FLAGS, 8'h20, 8'h20);
    rchk(SAR_OFF_RX_BUFFER, 8'hff, 8'h4b);
    rchk(SAR_OFF_FLAGS, 8'h20, 8'h00);
  endtask : t_rx
  task automatic t_addr();
    axw(SAR_OFF_RX_STATUS, 8'hd8);
    node.send(9'h033, 9, 1'h1);
    rchk(SAR_OFF_FLAGS, 8'h20, 8'h00);
    node.send(9'h1c7, 9, 1'h1);
    rchk(SAR_OFF_RX_STATUS, 8'h01, 8'h01);
    rchk(SAR_OFF_RX_BUFFER, 8'hff, 8'hc7);
    axw(SAR_OFF_RX_STATUS, 8'hd0);
    node.send(9'h02e, 9, 1'h1);
    rchk(SAR_OFF_RX_BUFFER, 8'hff, 8'h2e);
  endtask : t_addr
  task automatic t_err();
    axw(SAR_OFF_RX_STATUS, 8'h90);
    node.send(9'h011, 8, 1'h0);
    rchk(SAR_OFF_RX_STATUS, 8'h04, 8'h04);
    node.send(9'h022, 8, 1'h1);
    rchk(SAR_OFF_RX_STATUS, 8'h02, 8'h02);
    axw(SAR_OFF_RX_STATUS, 8'h80);
    rchk(SAR_OFF_RX_STATUS, 8'h06, 8'h00);
    rchk(SAR_OFF_RX_BUFFER, 8'hff, 8'h11);
  endtask : t_err
  task automatic t_wake();
    logic [7:0] d;
    logic [1:0] r;
    axw(SAR_OFF_RX_STATUS, 8'h90);
    axw(SAR_OFF_BAUD_CTRL, 8'h02);
    fork
      node.send(9'h000, 8, 1'h1);
      begin
        repeat (60) @(posedge aclk);
        rchk(SAR_OFF_FLAGS, 8'h20, 8'h20);
        rchk(SAR_OFF_BAUD_CTRL, 8'h02, 8'h02);
      end
    join
    // Rising line needs the synchroniser and one more clock to clear the enable
    repeat (4) @(posedge aclk);
    rchk(SAR_OFF_BAUD_CTRL, 8'h02, 8'h00);
    axr(SAR_OFF_RX_BUFFER, d, r);
    rchk(SAR_OFF_FLAGS, 8'h20, 8'h00);
    node.send(9'h03c, 8, 1'h1);
    rchk(SAR_OFF_RX_BUFFER, 8'hff, 8'h3c);
  endtask : t_wake
  task automatic t_sync();
    axw(SAR_OFF_TX_STATUS, 8'h90);
    repeat (2) @(posedge aclk);
    chk({7'h0, tx_pin}, 8'h00);
    axw(SAR_OFF_BAUD_CTRL, 8'h10);
    repeat (2) @(posedge aclk);
    chk({7'h0, tx_pin}, 8'h01);
  endtask : t_sync
  task automatic t_brk();
    int n;
    axw(SAR_OFF_TX_STATUS, 8'h2c);
    fork
      begin
        axw(SAR_OFF_TX_BUFFER, 8'hff);
        axw(SAR_OFF_TX_BUFFER, 8'h55);
      end
      low_run(n);
    join
    chk(n[7:0], 8'hd0);
    low_run(n);
    chk(n[7:0], 8'h10);
    rchk(SAR_OFF_TX_STATUS, 8'h08, 8'h00);
  endtask : t_brk
  task automatic t_brk_rx();
    // Device bit is 32 clocks; the line runs at about nine-thirteenths of that
    axw(SAR_OFF_DIV_LOW, 8'h01);
    node.bit_clks = 22;
    node.send(9'h000, 12, 1'h1);
    repeat (8) @(posedge aclk);
    rchk(SAR_OFF_RX_STATUS, 8'h04, 8'h00);
    rchk(SAR_OFF_RX_BUFFER, 8'hff, 8'h00);
  endtask : t_brk_rx
  initial begin
    errors = 0;
    check_count = 0;
    aresetn = 1'h0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    arvalid = 1'h0;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_rx();
    t_addr();
    t_err();
    t_wake();
    t_sync();
    t_brk();
    t_brk_rx();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    give_verdict();
  end
endmodule : tb_serial_async_rx_break_wake
